/* shared/rbs_pkg.sv */
package rbs_pkg;
    // register addresses on the host bus
    localparam logic [2:0] ADDR_RANDOM = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_EVENT = 3'h2;
    localparam logic [2:0] ADDR_PATTERN = 3'h3;
    localparam logic [2:0] ADDR_LOWER = 3'h4;
    localparam logic [2:0] ADDR_UPPER = 3'h5;
    localparam logic [2:0] ADDR_REMAIN = 3'h6;
    localparam logic [2:0] ADDR_TAP = 3'h7;
    // status/command bit positions
    localparam int STAT_READY_N = 0;
    localparam int STAT_INT_RESET = 1;
    localparam int STAT_FREE_RUN = 2;
    localparam int STAT_SELFTEST = 3;
    localparam int STAT_ALARM = 4;
    localparam int STAT_BUS_ERROR = 5;
    // random register geometry and counts
    localparam int RANDOM_BITS = 536;
    localparam logic [7:0] BYTE_COUNT = 8'h43;
    localparam int TEST_CYCLES = 18160;
    localparam int COMPARE_COUNT = 1000;
    localparam int FIFO_DEPTH = 16;
    // values after reset
    localparam logic [7:0] LOWER_RESET = 8'h00;
    localparam logic [7:0] UPPER_RESET = 8'hFF;
    localparam logic [3:0] PATTERN_RESET = 4'h0;
    localparam logic [7:0] SCRAMBLE_RESET = 8'h00;
    // engine states
    typedef enum logic [2:0] {
        RBS_IDLE,
        RBS_FILL,
        RBS_TEST,
        RBS_READY,
        RBS_HALT
    } rbs_state_type;
endpackage

/* design/rbs_core.sv */
// Summary of operation
// - status bits 6 and 7 always read zero
// - event count register holds last test match count, saturating at 255
// - master reset clears the event count
// - pattern register shows the pattern used by the last finished test
// - pattern counter advances only on a passing test
// - master reset leaves pattern counter and pattern register alone
// - lower limit register is read/write and bounds the test
// - upper limit register is read/write and bounds the test
// - byte counter loads 67 on data ready, counts reads, holds at zero
// - tap register catches each raw byte on the tap clock rising edge
// - host sets registers then pulses master reset to start generation
// - after start, fill all 536 bits, then begin the test
// - compare low four bits with pattern counter, count matches
// - after 1000 compares, count outside limits fails the test
// - one whole test lasts about 18160 clock periods
// - limits FF and 00 never fail
// - everything runs on the jitter clock, fast oscillator only sampled
// - pass raises data ready; after 67th read the next number starts only in free run
// - fail sets alarm, no data ready, reads repeat the same byte
// - address 0 gives the random number one byte per read strobe
// - random reads check bus data; mismatch sets bus error, alarm, halts
// - status bit 4 is the alarm, inverted on alarm_out_n, reset-only clear
// - free-run clear: one test then halt; set: restart after each readout
`timescale 1ns/1ps
`default_nettype none

module rbs_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = rbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_shape
        $error("fifo depth must be a power of two and width positive");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    // handshake and head word
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rd_ptr[AW-1:0]];

    // storage write
    always_ff @(posedge clock) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

module rbs_core #(
    parameter int TEST_CYCLES = rbs_pkg::TEST_CYCLES,
    parameter int COMPARE_COUNT = rbs_pkg::COMPARE_COUNT,
    parameter int FIFO_DEPTH = rbs_pkg::FIFO_DEPTH
) (
    // clock (jitter oscillator) and chip reset
    input wire logic clock,
    input wire logic rst_n,
    // device pins
    input wire logic master_reset_n,
    input wire logic fast_oscillator,
    output logic data_ready_n,
    output logic alarm_out_n,
    output logic tap_clock,
    // host parallel bus
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [2:0] address,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe
);
    localparam int SPACING = TEST_CYCLES / COMPARE_COUNT;

    if (COMPARE_COUNT < 1 || COMPARE_COUNT > 1023 || SPACING < 4 || SPACING > 32
        || TEST_CYCLES > 65536) begin : bad_timing
        $error("test window too short for non-overlapping four-bit compares");
    end

    rbs_pkg::rbs_state_type state;
    logic [rbs_pkg::RANDOM_BITS-1:0] random_reg;
    logic [9:0] fill_count;
    logic [15:0] cycle_count;
    logic [4:0] phase;
    logic [9:0] compare_done;
    logic [7:0] match_event_count;
    logic [3:0] pattern_counter;
    logic [3:0] test_pattern_value;
    logic [7:0] test_lower_bound;
    logic [7:0] test_upper_bound;
    logic [7:0] bytes_remaining_count;
    logic [7:0] raw_sample_tap;
    logic int_reset;
    logic free_run;
    logic alarm_selftest_cmd;
    logic alarm;
    logic bus_error;
    logic samp_a;
    logic samp_b;
    logic [7:0] scramble_hist;
    logic [7:0] raw_collect;
    logic [2:0] raw_bits;
    logic rd_prev;
    logic wr_prev;
    logic cs_prev;
    logic [2:0] addr_prev;
    logic mr_prev_active;

    // saturating increment of the match counter
    function automatic logic [7:0] sat_inc(input logic [7:0] value);
        sat_inc = (value == 8'hFF) ? value : value + 8'h01;
    endfunction

    // master reset: external pin or internal command bit
    wire mr_active = !master_reset_n || int_reset;
    wire start = mr_prev_active && !mr_active;

    // host strobe decode; actions happen as a strobe is released
    wire read_done = !rd_prev && read_n && !cs_prev;
    wire write_done = !wr_prev && write_n && !cs_prev;
    wire read_now = !read_n && !chip_select_n;
    wire random_read = read_done && (addr_prev == rbs_pkg::ADDR_RANDOM);
    wire readout = random_read && (state == rbs_pkg::RBS_READY);
    wire mismatch = random_read && (data_in != data_out);
    wire wr_status = write_done && (addr_prev == rbs_pkg::ADDR_STATUS);

    // entropy path: sample, two-sample parity, scrambler or fixed self-test sequence
    wire raw_bit = samp_a ^ samp_b;
    wire self_bit = scramble_hist[7] ^ scramble_hist[4] ^ 1'b1;
    wire mix_bit = raw_bit ^ scramble_hist[7] ^ scramble_hist[3];
    wire gen_bit = alarm_selftest_cmd ? self_bit : mix_bit;
    wire gen_ready;
    wire bit_valid;
    wire bit_data;
    wire gen_push = gen_ready && !mr_active;
    wire shifting = (state == rbs_pkg::RBS_FILL) || (state == rbs_pkg::RBS_TEST);
    wire take_bit = shifting && bit_valid;

    // test bookkeeping
    wire compare_hit = (state == rbs_pkg::RBS_TEST) && (phase == 5'(SPACING - 1))
        && (compare_done < 10'(COMPARE_COUNT));
    wire is_match = random_reg[3:0] == pattern_counter;
    wire test_end = (state == rbs_pkg::RBS_TEST) && (cycle_count == 16'(TEST_CYCLES - 1));
    // a compare landing on the last test cycle must still count toward the verdict
    wire [7:0] final_count = (compare_hit && is_match) ? sat_inc(match_event_count)
        : match_event_count;
    wire in_limits = (final_count >= test_lower_bound)
        && (final_count <= test_upper_bound);
    wire last_read = readout && (bytes_remaining_count == 8'h01);

    // status byte as read by the host
    wire [7:0] status_byte = {2'b00, bus_error, alarm, alarm_selftest_cmd,
        free_run, int_reset, data_ready_n};

    // read data mux
    logic [7:0] read_sel;
    always_comb begin
        case (address)
            rbs_pkg::ADDR_RANDOM: read_sel = random_reg[rbs_pkg::RANDOM_BITS-1 -: 8];
            rbs_pkg::ADDR_STATUS: read_sel = status_byte;
            rbs_pkg::ADDR_EVENT: read_sel = match_event_count;
            rbs_pkg::ADDR_PATTERN: read_sel = {4'h0, test_pattern_value};
            rbs_pkg::ADDR_LOWER: read_sel = test_lower_bound;
            rbs_pkg::ADDR_UPPER: read_sel = test_upper_bound;
            rbs_pkg::ADDR_REMAIN: read_sel = bytes_remaining_count;
            rbs_pkg::ADDR_TAP: read_sel = raw_sample_tap;
            default: read_sel = 8'h00;
        endcase
    end

    // bit buffer between entropy source and random register
    rbs_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(mr_active),
        .in_valid(!mr_active),
        .in_ready(gen_ready),
        .in_data(gen_bit),
        .out_valid(bit_valid),
        .out_ready(take_bit),
        .out_data(bit_data)
    );

    // bus sampling and read drive
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
            cs_prev <= 1'b1;
            addr_prev <= 3'h0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            rd_prev <= read_n;
            wr_prev <= write_n;
            cs_prev <= chip_select_n;
            addr_prev <= address;
            data_oe <= read_now;
            if (read_now) data_out <= read_sel;
        end
    end

    // writable registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_lower_bound <= rbs_pkg::LOWER_RESET;
            test_upper_bound <= rbs_pkg::UPPER_RESET;
            int_reset <= 1'b0;
            free_run <= 1'b0;
            alarm_selftest_cmd <= 1'b0;
        end else begin
            if (write_done && addr_prev == rbs_pkg::ADDR_LOWER) begin
                test_lower_bound <= data_in;
            end
            if (write_done && addr_prev == rbs_pkg::ADDR_UPPER) begin
                test_upper_bound <= data_in;
            end
            if (!master_reset_n) begin
                int_reset <= 1'b0;
                free_run <= 1'b0;
                alarm_selftest_cmd <= 1'b0;
            end else if (wr_status) begin
                int_reset <= data_in[rbs_pkg::STAT_INT_RESET];
                free_run <= data_in[rbs_pkg::STAT_FREE_RUN];
                alarm_selftest_cmd <= data_in[rbs_pkg::STAT_SELFTEST];
            end
        end
    end

    // entropy front end and raw byte tap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            samp_a <= 1'b0;
            samp_b <= 1'b0;
            scramble_hist <= rbs_pkg::SCRAMBLE_RESET;
            raw_collect <= 8'h00;
            raw_bits <= 3'h0;
            raw_sample_tap <= 8'h00;
            tap_clock <= 1'b0;
        end else begin
            samp_a <= fast_oscillator;
            samp_b <= samp_a;
            if (mr_active) begin
                scramble_hist <= rbs_pkg::SCRAMBLE_RESET;
            end else if (gen_push) begin
                scramble_hist <= {scramble_hist[6:0], gen_bit};
                raw_collect <= {raw_collect[6:0], raw_bit};
                raw_bits <= raw_bits + 3'h1;
                if (raw_bits == 3'h7) begin
                    raw_sample_tap <= {raw_collect[6:0], raw_bit};
                    tap_clock <= 1'b1;
                end else if (raw_bits == 3'h3) begin
                    tap_clock <= 1'b0;
                end
            end
        end
    end

    // pattern counter and pattern register survive master reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pattern_counter <= rbs_pkg::PATTERN_RESET;
            test_pattern_value <= rbs_pkg::PATTERN_RESET;
        end else if (test_end && !mr_active) begin
            test_pattern_value <= pattern_counter;
            if (in_limits) pattern_counter <= pattern_counter + 4'h1;
        end
    end

    // run engine: fill, test, hand out bytes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= rbs_pkg::RBS_IDLE;
            random_reg <= '0;
            fill_count <= 10'h000;
            cycle_count <= 16'h0000;
            phase <= 5'h00;
            compare_done <= 10'h000;
            match_event_count <= 8'h00;
            bytes_remaining_count <= 8'h00;
            alarm <= 1'b0;
            bus_error <= 1'b0;
            mr_prev_active <= 1'b0;
            data_ready_n <= 1'b1;
            alarm_out_n <= 1'b1;
        end else begin
            mr_prev_active <= mr_active;
            alarm_out_n <= !alarm;
            if (mr_active) begin
                state <= rbs_pkg::RBS_IDLE;
                match_event_count <= 8'h00;
                bytes_remaining_count <= 8'h00;
                alarm <= 1'b0;
                bus_error <= 1'b0;
                data_ready_n <= 1'b1;
                if (int_reset) random_reg <= '0;
            end else begin
                if (take_bit) random_reg <= {random_reg[rbs_pkg::RANDOM_BITS-2:0], bit_data};
                if (mismatch) begin
                    bus_error <= 1'b1;
                    alarm <= 1'b1;
                    data_ready_n <= 1'b1;
                    state <= rbs_pkg::RBS_HALT;
                end else begin
                    case (state)
                        rbs_pkg::RBS_IDLE: begin
                            if (start) begin
                                fill_count <= 10'h000;
                                state <= rbs_pkg::RBS_FILL;
                            end
                        end
                        rbs_pkg::RBS_FILL: begin
                            if (take_bit) fill_count <= fill_count + 10'h001;
                            if (take_bit && fill_count == 10'(rbs_pkg::RANDOM_BITS - 1)) begin
                                cycle_count <= 16'h0000;
                                phase <= 5'h00;
                                compare_done <= 10'h000;
                                match_event_count <= 8'h00;
                                state <= rbs_pkg::RBS_TEST;
                            end
                        end
                        rbs_pkg::RBS_TEST: begin
                            cycle_count <= cycle_count + 16'h0001;
                            phase <= (phase == 5'(SPACING - 1)) ? 5'h00 : phase + 5'h01;
                            if (compare_hit) begin
                                compare_done <= compare_done + 10'h001;
                                if (is_match) match_event_count <= sat_inc(match_event_count);
                            end
                            if (test_end) begin
                                if (in_limits) begin
                                    data_ready_n <= 1'b0;
                                    bytes_remaining_count <= rbs_pkg::BYTE_COUNT;
                                    state <= rbs_pkg::RBS_READY;
                                end else begin
                                    alarm <= 1'b1;
                                    state <= rbs_pkg::RBS_HALT;
                                end
                            end
                        end
                        rbs_pkg::RBS_READY: begin
                            if (readout) begin
                                random_reg <= {random_reg[rbs_pkg::RANDOM_BITS-9:0], 8'h00};
                                bytes_remaining_count <= bytes_remaining_count - 8'h01;
                            end
                            if (last_read) begin
                                data_ready_n <= 1'b1;
                                fill_count <= 10'h000;
                                state <= free_run ? rbs_pkg::RBS_FILL : rbs_pkg::RBS_HALT;
                            end
                        end
                        rbs_pkg::RBS_HALT: begin
                            state <= rbs_pkg::RBS_HALT;
                        end
                        default: begin
                            state <= rbs_pkg::RBS_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule

`default_nettype wire

/* bench/rbs_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module rbs_core_asserts #(
    parameter int TEST_CYCLES = rbs_pkg::TEST_CYCLES,
    parameter int COMPARE_COUNT = rbs_pkg::COMPARE_COUNT,
    parameter int FIFO_DEPTH = rbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // device pins
    input wire logic master_reset_n,
    input wire logic fast_oscillator,
    input wire logic data_ready_n,
    input wire logic alarm_out_n,
    input wire logic tap_clock,
    // host bus
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [2:0] address,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [3:0] wr_hist;
    logic [15:0] since_mr;
    // recent write strobes and cycles since master reset went inactive
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_hist <= 4'hF;
            since_mr <= 16'h0000;
        end else begin
            wr_hist <= {wr_hist[2:0], write_n};
            since_mr <= !master_reset_n ? 16'h0000 : since_mr + {15'h0000, ~&since_mr};
        end
    end
    AST_ALARM_HOLDS: assert property (
        !alarm_out_n && master_reset_n && $past(master_reset_n) && wr_hist == 4'hF
        |=> !alarm_out_n) else $error("alarm pin released without reset");
    AST_MR_CLEARS_ALARM: assert property (
        !master_reset_n |-> ##2 alarm_out_n) else $error("alarm kept through master reset");
    AST_MR_CLEARS_READY: assert property (
        !master_reset_n |=> data_ready_n) else $error("data ready kept through master reset");
    AST_FILL_FIRST: assert property (
        $fell(data_ready_n) |-> since_mr >= rbs_pkg::RANDOM_BITS + TEST_CYCLES - 1)
        else $error("data ready before fill and test finished");
    AST_READY_HOLDS: assert property (
        !data_ready_n && master_reset_n && read_n && $past(read_n) && wr_hist == 4'hF
        |=> !data_ready_n) else $error("data ready dropped without a read");
    AST_STATUS_TOP: assert property (
        !read_n && !chip_select_n && address == rbs_pkg::ADDR_STATUS
        |=> data_out[7:6] == 2'b00) else $error("status top bits not zero");
    AST_OE_ON: assert property (
        !read_n && !chip_select_n |=> data_oe) else $error("bus not driven during read");
    AST_OE_OFF: assert property (
        read_n |=> !data_oe) else $error("bus driven after read");
    AST_OUT_HOLDS: assert property (
        $past(read_n) || $past(chip_select_n) |-> $stable(data_out))
        else $error("read data changed outside a read");
    AST_TAP_WIDTH: assert property (
        $rose(tap_clock) |-> tap_clock [*4]) else $error("tap clock pulse too short");
    AST_ALARM_NO_READY: assert property (
        !alarm_out_n |-> data_ready_n) else $error("data ready during alarm");
endmodule

bind rbs_core rbs_core_asserts #(
    .TEST_CYCLES(TEST_CYCLES),
    .COMPARE_COUNT(COMPARE_COUNT),
    .FIFO_DEPTH(FIFO_DEPTH)
) i_rbs_core_asserts (
    .clock(clock), .rst_n(rst_n), .master_reset_n(master_reset_n),
    .fast_oscillator(fast_oscillator), .data_ready_n(data_ready_n),
    .alarm_out_n(alarm_out_n), .tap_clock(tap_clock), .chip_select_n(chip_select_n),
    .read_n(read_n), .write_n(write_n), .address(address), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe)
);

`default_nettype wire

/* bench/rbs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rbs_host_model (
    // clock and device answers
    input wire logic clock,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    // reset pin and bus requests
    output logic master_reset_n,
    output logic chip_select_n,
    output logic read_n,
    output logic write_n,
    output logic [2:0] address,
    output logic [7:0] data_in
);
    logic host_en = 1'b0;
    logic [7:0] host_data = 8'h00;
    logic [7:0] last_bus = 8'h00;
    logic [7:0] fault_mask = 8'h00;
    // bus wire: host drive, device drive with optional contention, else drifting
    assign data_in = host_en ? host_data : (data_oe ? data_out ^ fault_mask : ~last_bus);
    always_ff @(posedge clock) last_bus <= data_in;
    // idle levels
    initial begin
        master_reset_n = 1'b1;
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        address = 3'h0;
    end
    // write: data stays on the wire through the release cycle
    task bus_write(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock);
        chip_select_n = 1'b0;
        write_n = 1'b0;
        address = a;
        host_en = 1'b1;
        host_data = d;
        repeat (2) @(negedge clock);
        write_n = 1'b1;
        @(negedge clock);
        chip_select_n = 1'b1;
        host_en = 1'b0;
        @(negedge clock);
    endtask
    // read: the device drives the wire, host only samples it (no reads of tap as random)
    task bus_read(input logic [2:0] a, output logic [7:0] d);
        @(negedge clock);
        chip_select_n = 1'b0;
        read_n = 1'b0;
        address = a;
        repeat (2) @(negedge clock);
        d = data_in;
        read_n = 1'b1;
        @(negedge clock);
        chip_select_n = 1'b1;
        @(negedge clock);
    endtask
    // master reset pulse starts generation after setup
    task pulse_mr;
        @(negedge clock);
        master_reset_n = 1'b0;
        repeat (2) @(negedge clock);
        master_reset_n = 1'b1;
        @(negedge clock);
    endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic fast_oscillator = 1'b0;
    logic osc_run = 1'b0;
    logic master_reset_n, chip_select_n, read_n, write_n;
    logic data_ready_n, alarm_out_n, tap_clock, data_oe;
    logic [2:0] address;
    logic [7:0] data_in, data_out, v, w;
    int err_count = 0;
    int checks = 0;
    int n;
    // clock and entropy input, stuck low or toggling every cycle
    always #5 clock = ~clock;
    always @(negedge clock) fast_oscillator <= osc_run & ~fast_oscillator;
    rbs_core #(.TEST_CYCLES(1200), .COMPARE_COUNT(300)) i_rbs_core (
        .clock(clock), .rst_n(rst_n), .master_reset_n(master_reset_n),
        .fast_oscillator(fast_oscillator), .data_ready_n(data_ready_n),
        .alarm_out_n(alarm_out_n), .tap_clock(tap_clock), .chip_select_n(chip_select_n),
        .read_n(read_n), .write_n(write_n), .address(address), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    rbs_host_model i_rbs_host_model (
        .clock(clock), .data_out(data_out), .data_oe(data_oe),
        .master_reset_n(master_reset_n), .chip_select_n(chip_select_n), .read_n(read_n),
        .write_n(write_n), .address(address), .data_in(data_in));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        i_rbs_host_model.bus_read(a, v);
        check(v, e);
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        i_rbs_host_model.bus_write(a, d);
    endtask
    // wait for data ready (0), alarm (1) or tap clock (2) to reach a level
    task wait_for(input int sel, input logic lvl);
        n = 0;
        while (n < 4000 && (sel == 2 ? tap_clock : (sel == 1 ? alarm_out_n : data_ready_n)) !== lvl) begin
            @(negedge clock);
            n++;
        end
        check(8'(n < 4000), 8'h01);
    endtask
    task test_done;
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (30000) @(posedge clock);
        err_count++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        rd(rbs_pkg::ADDR_LOWER, 8'h00);
        rd(rbs_pkg::ADDR_UPPER, 8'hFF);
        wr(rbs_pkg::ADDR_EVENT, 8'h55);
        rd(rbs_pkg::ADDR_EVENT, 8'h00);
        wr(rbs_pkg::ADDR_STATUS, 8'hC4);
        rd(rbs_pkg::ADDR_STATUS, 8'h05);
        // stuck input gives zeros: every compare matches pattern 0 and saturates
        i_rbs_host_model.pulse_mr;
        rd(rbs_pkg::ADDR_STATUS, 8'h01);
        wait_for(0, 1'b0);
        rd(rbs_pkg::ADDR_EVENT, 8'hFF);
        rd(rbs_pkg::ADDR_PATTERN, 8'h00);
        rd(rbs_pkg::ADDR_REMAIN, 8'h43);
        for (int i = 0; i < 67; i++) begin
            rd(rbs_pkg::ADDR_RANDOM, 8'h00);
            if (i == 0) rd(rbs_pkg::ADDR_REMAIN, 8'h42);
        end
        check({7'h00, data_ready_n}, 8'h01);
        rd(rbs_pkg::ADDR_RANDOM, 8'h00);
        rd(rbs_pkg::ADDR_REMAIN, 8'h00);
        repeat (2500) @(negedge clock);
        check({7'h00, data_ready_n}, 8'h01);
        // pattern 1 never matches: count 0 under lower bound 01
        wr(rbs_pkg::ADDR_LOWER, 8'h01);
        wr(rbs_pkg::ADDR_UPPER, 8'hFE);
        rd(rbs_pkg::ADDR_LOWER, 8'h01);
        rd(rbs_pkg::ADDR_UPPER, 8'hFE);
        i_rbs_host_model.pulse_mr;
        rd(rbs_pkg::ADDR_EVENT, 8'h00);
        wait_for(1, 1'b0);
        check({7'h00, data_ready_n}, 8'h01);
        rd(rbs_pkg::ADDR_STATUS, 8'h11);
        rd(rbs_pkg::ADDR_EVENT, 8'h00);
        rd(rbs_pkg::ADDR_PATTERN, 8'h01);
        i_rbs_host_model.bus_read(rbs_pkg::ADDR_RANDOM, w);
        rd(rbs_pkg::ADDR_RANDOM, w);
        // open limits: same pattern retested and passes, then bus contention
        wr(rbs_pkg::ADDR_LOWER, 8'h00);
        wr(rbs_pkg::ADDR_UPPER, 8'hFF);
        i_rbs_host_model.pulse_mr;
        check({7'h00, alarm_out_n}, 8'h01);
        rd(rbs_pkg::ADDR_PATTERN, 8'h01);
        wait_for(0, 1'b0);
        rd(rbs_pkg::ADDR_PATTERN, 8'h01);
        rd(rbs_pkg::ADDR_EVENT, 8'h00);
        rd(rbs_pkg::ADDR_RANDOM, 8'h00);
        rd(rbs_pkg::ADDR_REMAIN, 8'h42);
        i_rbs_host_model.fault_mask = 8'h5A;
        i_rbs_host_model.bus_read(rbs_pkg::ADDR_RANDOM, w);
        i_rbs_host_model.fault_mask = 8'h00;
        rd(rbs_pkg::ADDR_STATUS, 8'h31);
        check({7'h00, alarm_out_n}, 8'h00);
        // toggling input makes every raw bit one
        osc_run = 1'b1;
        i_rbs_host_model.pulse_mr;
        rd(rbs_pkg::ADDR_STATUS, 8'h01);
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        wait_for(2, 1'b1);
        rd(rbs_pkg::ADDR_TAP, 8'hFF);
        // free run: after a full readout the device refills and tests again
        wr(rbs_pkg::ADDR_STATUS, 8'h04);
        wait_for(0, 1'b0);
        for (int i = 0; i < 67; i++) i_rbs_host_model.bus_read(rbs_pkg::ADDR_RANDOM, w);
        check({7'h00, data_ready_n}, 8'h01);
        wait_for(0, 1'b0);
        rd(rbs_pkg::ADDR_REMAIN, 8'h43);
        rd(rbs_pkg::ADDR_STATUS, 8'h04);
        test_done;
    end
endmodule

`default_nettype wire
